/* core/spvp_pkg.sv */
package spvp_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    // bulk erase time, value not given: plain default
    localparam int BULK_ERASE_TIME_US = 5;
    localparam int BULK_ERASE_CYCLES = BULK_ERASE_TIME_US * CLK_MHZ;
    // ****************************************
    // address map
    // ****************************************
    localparam logic [11:0] TP_LOW_ADDR = 12'hff6;
    localparam logic [11:0] TP_HIGH_ADDR = 12'hff7;
    localparam logic [11:0] TP_UPPER_ADDR = 12'hff8;
    localparam logic [21:0] CODE_END = 22'h00ffff;
    localparam logic [21:0] BOOT_END = 22'h0007ff;
    localparam logic [21:0] ID_BASE = 22'h200000;
    localparam logic [21:0] ID_END = 22'h200007;
    localparam logic [21:0] CFG_BASE = 22'h300000;
    localparam logic [21:0] CFG_END = 22'h30000d;
    localparam logic [21:0] DEVID_BASE = 22'h3ffffe;
    localparam logic [21:0] ERASE_OPT_ADDR = 22'h3c0004;
    localparam logic [21:0] PROG_CTRL_ADDR = 22'h3c0006;
    localparam int PANEL_LSB = 13;
    localparam int BLOCK_LSB = 14;
    localparam int MULTI_PANEL_BIT = 0;
    localparam logic [7:0] ERASE_OPT_RST = 8'h00;
    localparam logic [7:0] PROG_CTRL_RST = 8'h00;
    localparam logic [21:0] TP_RST = 22'h000000;
    // ****************************************
    // serial frame
    // ****************************************
    localparam logic [4:0] CMD_LAST_BIT = 5'h03;
    localparam logic [4:0] IN_LAST_BIT = 5'h0b;
    localparam logic [4:0] OUT_FIRST_BIT = 5'h0c;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h13;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_TBL_READ = 4'h8;
    localparam logic [3:0] CMD_TBL_READ_INC = 4'h9;
    localparam logic [3:0] CMD_TBL_WRITE = 4'hc;
    localparam logic [3:0] CMD_TBL_WRITE_INC = 4'hd;
    localparam logic [3:0] CMD_START_PROG = 4'hf;

    typedef enum logic [1:0] {PV_OFF, PV_HV, PV_LV} spvp_mode_e;

    typedef struct packed {
        logic clk;
        logic dat;
        logic hv;
        logic vih;
        logic lvpin;
    } spvp_pins_s;

    typedef struct packed {
        logic valid;
        logic [15:0] instr;
    } spvp_core_s;
endpackage

/* core/spvp_port.sv */
`timescale 1ns/1ps
module spvp_port
    import spvp_pkg::*;
#(
    parameter int BULK_ERASE_CYCLES_P = BULK_ERASE_CYCLES
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pins, unsynchronised
    input wire spvp_pins_s pin_in,
    input wire logic low_volt_enable_bit,
    output logic prog_data_out,
    output logic prog_data_oe,
    // mode
    output logic io_hiz,
    output logic lv_pin_dedicated,
    // core instruction hand-off
    output spvp_core_s core_out,
    // special function registers
    input wire logic sfr_we,
    input wire logic [11:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // memory array
    output logic [21:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic [4:0] prot_on,
    // erase and programming
    output logic bulk_erase_busy,
    output logic [7:0] erase_sel,
    output logic prot_clear,
    output logic prog_active,
    output logic multi_panel,
    input wire logic [5:0] wbuf_rd_idx,
    output logic [7:0] wbuf_rd_data
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        spvp_pins_s s1;
        spvp_pins_s s2;
        spvp_pins_s prev;
        spvp_mode_e mode;
        logic [4:0] bitcnt;
        logic [19:0] sh;
        logic [7:0] dout;
        logic obit;
        logic oe;
        logic [21:0] tp;
        logic [7:0] erase_opt;
        logic [7:0] prog_ctrl;
        logic erase_armed;
        logic prog_armed;
        logic prog_act;
        logic busy;
        logic [31:0] ecnt;
        logic pclr;
        spvp_core_s core;
        logic [63:0][7:0] wbuf;
    } spvp_state_s;

    spvp_state_s st_reg;
    spvp_state_s st_next;

    if (BULK_ERASE_CYCLES_P < 1)
    begin : g_chk
        $error("bulk erase cycle count must be at least one");
    end

    // ****************************************
    // read path
    // ****************************************
    function automatic logic [7:0] read_byte(input logic [21:0] a, input logic [7:0] eo,
                                             input logic [7:0] pc, input logic [7:0] md,
                                             input logic [4:0] pr);
        logic prot;
        prot = (a <= BOOT_END) ? pr[0] : pr[3'({1'b0, a[15:BLOCK_LSB]}) + 3'h1];
        read_byte = 8'h00;
        if (a == ERASE_OPT_ADDR)
            read_byte = eo;
        else if (a == PROG_CTRL_ADDR)
            read_byte = pc;
        else if (a <= CODE_END)
            read_byte = prot ? 8'h00 : md;
        else if (a >= ID_BASE && a <= ID_END)
            read_byte = md;
        else if (a >= CFG_BASE && a <= CFG_END)
            read_byte = md;
        else if (a >= DEVID_BASE)
            read_byte = md;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic rise;
        logic fall;
        logic [15:0] op;
        logic [3:0] cmd;
        st_next = st_reg;
        rise = 1'b0;
        fall = 1'b0;
        op = 16'h0000;
        cmd = st_reg.sh[3:0];
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.prev = st_reg.s2;
        st_next.core.valid = 1'b0;
        st_next.pclr = 1'b0;

        // entry and exit
        unique case (st_reg.mode)
            PV_OFF:
            begin
                if (st_reg.s2.hv && !st_reg.prev.hv && !st_reg.s2.clk && !st_reg.s2.dat)
                    st_next.mode = PV_HV;
                else if (low_volt_enable_bit && st_reg.s2.lvpin && st_reg.s2.vih && !st_reg.prev.vih
                         && !st_reg.s2.clk && !st_reg.s2.dat)
                    st_next.mode = PV_LV;
            end
            PV_HV, PV_LV:
            begin
                if (!st_reg.s2.hv && !st_reg.s2.vih)
                    st_next.mode = PV_OFF;
                else
                begin
                    rise = st_reg.s2.clk && !st_reg.prev.clk;
                    fall = !st_reg.s2.clk && st_reg.prev.clk;
                end
            end
        endcase

        if (st_next.mode == PV_OFF)
        begin
            st_next.bitcnt = 5'h00;
            st_next.oe = 1'b0;
            st_next.prog_act = 1'b0;
            st_next.prog_armed = 1'b0;
            st_next.erase_armed = 1'b0;
        end

        // self-timed bulk erase, serial shifting halted
        if (st_reg.busy)
        begin
            if (st_reg.ecnt >= 32'(BULK_ERASE_CYCLES_P - 1))
            begin
                st_next.busy = 1'b0;
                st_next.pclr = 1'b1;
            end
            else
                st_next.ecnt = st_reg.ecnt + 32'h1;
        end
        else
        begin
            if (rise)
            begin
                if (st_reg.bitcnt == CMD_LAST_BIT && st_reg.prog_armed)
                    st_next.prog_act = 1'b1;
                if ((cmd[3:1] == CMD_TBL_READ[3:1]) && st_reg.bitcnt >= OUT_FIRST_BIT)
                begin
                    st_next.oe = 1'b1;
                    st_next.obit = st_reg.dout[3'(st_reg.bitcnt - OUT_FIRST_BIT)];
                end
            end
            if (fall)
            begin
                st_next.sh[st_reg.bitcnt] = st_reg.s2.dat;
                st_next.bitcnt = st_reg.bitcnt + 5'h01;
                if (st_reg.bitcnt == CMD_LAST_BIT)
                begin
                    st_next.prog_act = 1'b0;
                    st_next.prog_armed = 1'b0;
                    if (st_reg.erase_armed)
                    begin
                        st_next.erase_armed = 1'b0;
                        st_next.busy = 1'b1;
                        st_next.ecnt = 32'h0;
                    end
                end
                if (st_reg.bitcnt == IN_LAST_BIT)
                    st_next.dout = read_byte(st_reg.tp, st_reg.erase_opt, st_reg.prog_ctrl,
                                             mem_rdata, prot_on);
                if (st_reg.bitcnt == FRAME_LAST_BIT)
                begin
                    st_next.bitcnt = 5'h00;
                    st_next.oe = 1'b0;
                    op = {st_reg.s2.dat, st_reg.sh[18:4]};
                    unique case (cmd)
                        CMD_CORE:
                        begin
                            st_next.core.valid = 1'b1;
                            st_next.core.instr = op;
                        end
                        CMD_TBL_READ, CMD_TBL_READ_INC:
                        begin
                            if (cmd[0])
                                st_next.tp = st_reg.tp + 22'h1;
                        end
                        CMD_TBL_WRITE, CMD_TBL_WRITE_INC:
                        begin
                            if (st_reg.tp == ERASE_OPT_ADDR)
                            begin
                                st_next.erase_opt = op[7:0];
                                st_next.erase_armed = 1'b1;
                            end
                            else if (st_reg.tp == PROG_CTRL_ADDR)
                                st_next.prog_ctrl = op[7:0];
                            else if (st_reg.tp <= CODE_END || (st_reg.tp >= ID_BASE && st_reg.tp <= ID_END))
                                st_next.wbuf[{st_reg.tp[PANEL_LSB+2:PANEL_LSB], st_reg.tp[2:0]}] = op[7:0];
                            if (cmd[0])
                                st_next.tp = st_reg.tp + 22'h1;
                        end
                        CMD_START_PROG:
                            st_next.prog_armed = 1'b1;
                        default:
                        begin
                        end
                    endcase
                end
            end
        end

        // core writes to the table pointer bytes
        if (sfr_we)
        begin
            unique case (sfr_addr)
                TP_LOW_ADDR: st_next.tp[7:0] = sfr_wdata;
                TP_HIGH_ADDR: st_next.tp[15:8] = sfr_wdata;
                TP_UPPER_ADDR: st_next.tp[21:16] = sfr_wdata[5:0];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
            st_reg.mode <= PV_OFF;
            st_reg.tp <= TP_RST;
            st_reg.erase_opt <= ERASE_OPT_RST;
            st_reg.prog_ctrl <= PROG_CTRL_RST;
        end
        else
            st_reg <= st_next;
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb
    begin
        unique case (sfr_addr)
            TP_LOW_ADDR: sfr_rdata = st_reg.tp[7:0];
            TP_HIGH_ADDR: sfr_rdata = st_reg.tp[15:8];
            TP_UPPER_ADDR: sfr_rdata = {2'h0, st_reg.tp[21:16]};
            default: sfr_rdata = 8'h00;
        endcase
    end

    assign prog_data_out = st_reg.obit;
    assign prog_data_oe = st_reg.oe;
    assign io_hiz = (st_reg.mode != PV_OFF);
    assign lv_pin_dedicated = (st_reg.mode == PV_LV);
    assign core_out = st_reg.core;
    assign mem_addr = st_reg.tp;
    assign bulk_erase_busy = st_reg.busy;
    assign erase_sel = st_reg.erase_opt;
    assign prot_clear = st_reg.pclr;
    assign prog_active = st_reg.prog_act;
    assign multi_panel = st_reg.prog_ctrl[MULTI_PANEL_BIT];
    assign wbuf_rd_data = st_reg.wbuf[wbuf_rd_idx];

endmodule

/* dv/spvp_port_chk.sv */
`timescale 1ns/1ps
module spvp_port_chk
    import spvp_pkg::*;
#(
    parameter int BULK_ERASE_CYCLES_P = BULK_ERASE_CYCLES
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pins and mode
    input wire spvp_pins_s pin_in,
    input wire logic low_volt_enable_bit,
    input wire logic prog_data_oe,
    input wire logic io_hiz,
    input wire logic lv_pin_dedicated,
    input wire spvp_core_s core_out,
    // pointer
    input wire logic [11:0] sfr_addr,
    input wire logic [7:0] sfr_rdata,
    input wire logic [21:0] mem_addr,
    // erase and programming
    input wire logic bulk_erase_busy,
    input wire logic prot_clear,
    input wire logic prog_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    int busy_cnt_reg;
    int busy_cnt_next;
    // cycles of the running erase
    always_comb busy_cnt_next = bulk_erase_busy ? busy_cnt_reg + 1 : 0;
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= busy_cnt_next;
    mode_exit_a: assert property ((!pin_in.hv && !pin_in.vih) [*8] |-> !io_hiz)
        else $error("mode kept");
    lv_gate_a: assert property ($rose(lv_pin_dedicated) |-> low_volt_enable_bit && pin_in.lvpin && io_hiz)
        else $error("bad lv entry");
    drive_mode_a: assert property (prog_data_oe |-> io_hiz)
        else $error("drive off mode");
    instr_pulse_a: assert property (core_out.valid |-> io_hiz ##1 !core_out.valid)
        else $error("bad instr pulse");
    erase_len_a: assert property ($fell(bulk_erase_busy) |-> busy_cnt_reg == BULK_ERASE_CYCLES_P)
        else $error("erase length");
    erase_clear_a: assert property ($fell(bulk_erase_busy) |-> ##[0:2] prot_clear)
        else $error("no clear");
    ptr_read_a: assert property (sfr_addr == TP_UPPER_ADDR |-> sfr_rdata == {2'b00, mem_addr[21:16]})
        else $error("upper byte");
    prog_mode_a: assert property (prog_active |-> io_hiz && !bulk_erase_busy)
        else $error("prog off mode");
endmodule
bind spvp_port spvp_port_chk #(.BULK_ERASE_CYCLES_P(BULK_ERASE_CYCLES_P)) spvp_port_chk_inst (
    .core_clk(core_clk), .nrst(nrst), .pin_in(pin_in), .low_volt_enable_bit(low_volt_enable_bit),
    .prog_data_oe(prog_data_oe), .io_hiz(io_hiz), .lv_pin_dedicated(lv_pin_dedicated), .core_out(core_out),
    .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .mem_addr(mem_addr), .bulk_erase_busy(bulk_erase_busy),
    .prot_clear(prot_clear), .prog_active(prog_active));

/* dv/spvp_prog_model.sv */
`timescale 1ns/1ps
module spvp_prog_model
    import spvp_pkg::*;
(
    // device side
    input wire logic core_clk,
    input wire logic prog_data_out,
    input wire logic prog_data_oe,
    // pins
    output spvp_pins_s pins
);
    spvp_pins_s p = '0;
    logic drv_en = 1'b1;
    // released line shows the inverse of its last level
    assign pins = '{clk: p.clk, dat: prog_data_oe ? prog_data_out : (drv_en ? p.dat : ~p.dat),
        hv: p.hv, vih: p.vih, lvpin: p.lvpin};
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic enter(input logic lv);
        p = '0;
        p.lvpin = lv;
        wait_n(4);
        p.hv = !lv;
        p.vih = lv;
        wait_n(8);
    endtask
    task automatic leave;
        p = '0;
        wait_n(8);
    endtask
    task automatic frame(input logic [3:0] cmd, input logic [15:0] op, input int hi, input int lo,
        output logic [7:0] rd);
        logic [19:0] bits;
        bits = {op, cmd};
        rd = 8'h00;
        for (int i = 0; i < 20; i++)
        begin
            p.clk = 1'b1;
            drv_en = i < 12 || cmd[3:1] != 3'b100;
            if (drv_en)
                p.dat = bits[i];
            wait_n(i == 3 ? 8 + hi : 8);
            if (!drv_en)
                rd[i - 12] = pins.dat;
            p.clk = 1'b0;
            // take the line back one cycle after the last fall, clear of the next frame's first step
            wait_n(1);
            if (i == 19)
            begin
                drv_en = 1'b1;
                p.dat = 1'b0;
            end
            wait_n(i == 3 ? 7 + lo : 7);
        end
    endtask
endmodule

/* dv/spvp_port_tb.sv */
`timescale 1ns/1ps
module spvp_port_tb;
    import spvp_pkg::*;
    localparam int BE_CYC = 8;
    logic core_clk = 1'b0, nrst = 1'b0, low_volt_enable_bit = 1'b0, sfr_we = 1'b0;
    logic prog_data_out, prog_data_oe, io_hiz, lv_pin_dedicated, bulk_erase_busy, prot_clear, prog_active;
    logic multi_panel;
    logic [11:0] sfr_addr = 12'h000;
    logic [7:0] sfr_wdata = 8'h00, sfr_rdata, mem_rdata, erase_sel, wbuf_rd_data, rd, v;
    logic [4:0] prot_on = 5'h00;
    logic [5:0] wbuf_rd_idx = 6'h00;
    logic [21:0] mem_addr;
    logic [15:0] last_instr;
    spvp_pins_s pin_in;
    spvp_core_s core_out;
    integer seed = 95947;
    int num_errors = 0, check_count = 0, pulses = 0, busy_n = 0, clr_n = 0, act_n = 0, n, k;
    logic [21:0] addrs[$] = '{22'h000100, 22'h004321, 22'h00e123, 22'h200003, CFG_END, DEVID_BASE, 22'h3fffff,
        22'h250000};
    always #5 core_clk = ~core_clk;
    assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
    spvp_port #(.BULK_ERASE_CYCLES_P(BE_CYC)) spvp_port_inst (.core_clk(core_clk), .nrst(nrst), .pin_in(pin_in),
        .low_volt_enable_bit(low_volt_enable_bit), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
        .io_hiz(io_hiz), .lv_pin_dedicated(lv_pin_dedicated), .core_out(core_out), .sfr_we(sfr_we),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .prot_on(prot_on), .bulk_erase_busy(bulk_erase_busy), .erase_sel(erase_sel),
        .prot_clear(prot_clear), .prog_active(prog_active), .multi_panel(multi_panel),
        .wbuf_rd_idx(wbuf_rd_idx), .wbuf_rd_data(wbuf_rd_data));
    spvp_prog_model spvp_prog_model_inst (.core_clk(core_clk), .prog_data_out(prog_data_out),
        .prog_data_oe(prog_data_oe), .pins(pin_in));
    always @(posedge core_clk)
    begin
        if (core_out.valid === 1'b1)
            last_instr <= core_out.instr;
        pulses <= pulses + int'(core_out.valid === 1'b1);
        busy_n <= busy_n + int'(bulk_erase_busy === 1'b1);
        clr_n <= clr_n + int'(prot_clear === 1'b1);
        act_n <= act_n + int'(prog_active === 1'b1);
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] exp_rd(input logic [21:0] ad, input logic [4:0] pr);
        if (ad <= CODE_END)
            return pr[ad <= BOOT_END ? 0 : 1 + ad[15:14]] ? 8'h00 : ad[7:0] ^ 8'h5a;
        if (ad >= ID_BASE && ad <= ID_END || ad >= CFG_BASE && ad <= CFG_END || ad >= DEVID_BASE)
            return ad[7:0] ^ 8'h5a;
        return 8'h00;
    endfunction
    task automatic fr(input logic [3:0] c, input logic [15:0] o, input int hi, input int lo);
        spvp_prog_model_inst.frame(c, o, hi, lo, rd);
    endtask
    task automatic sfr_wr(input logic [11:0] ad, input logic [7:0] d);
        @(negedge core_clk);
        sfr_we = 1'b1;
        sfr_addr = ad;
        sfr_wdata = d;
        @(negedge core_clk);
        sfr_we = 1'b0;
    endtask
    task automatic tp_set(input logic [21:0] t);
        sfr_wr(TP_LOW_ADDR, t[7:0]);
        sfr_wr(TP_HIGH_ADDR, t[15:8]);
        sfr_wr(TP_UPPER_ADDR, {2'b00, t[21:16]});
        @(negedge core_clk);
        chk("upper byte", {14'h0000, 2'b00, t[21:16]}, {14'h0000, sfr_rdata});
        chk("pointer", t, mem_addr);
    endtask
    task automatic core_chk(input logic [15:0] o);
        k = pulses;
        fr(CMD_CORE, o, 0, 0);
        spvp_prog_model_inst.wait_n(8);
        chk("instr count", 22'(k + 1), 22'(pulses));
        chk("instr", {6'h00, o}, {6'h00, last_instr});
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        chk("pointer", TP_RST, mem_addr);
        spvp_prog_model_inst.enter(1'b1);
        fr(CMD_CORE, 16'h1234, 0, 0);
        chk("lv refused", 22'h0, {20'h0, io_hiz, 1'b0});
        chk("ignored", 22'h0, 22'(pulses));
        spvp_prog_model_inst.leave;
        low_volt_enable_bit = 1'b1;
        spvp_prog_model_inst.enter(1'b1);
        chk("lv mode", 22'h3, {20'h0, io_hiz, lv_pin_dedicated});
        spvp_prog_model_inst.leave;
        low_volt_enable_bit = 1'b0;
        spvp_prog_model_inst.enter(1'b0);
        chk("hv mode", 22'h2, {20'h0, io_hiz, lv_pin_dedicated});
        repeat (3) core_chk(16'($random(seed)));
        for (int q = 0; q < 2; q++)
        begin
            prot_on = q ? 5'h1f : 5'h00;
            addrs.push_back(22'($random(seed)) & CODE_END);
            foreach (addrs[i])
            begin
                tp_set(addrs[i]);
                fr(i[0] ? CMD_TBL_READ_INC : CMD_TBL_READ, 16'(i), 0, 0);
                chk("read", {14'h0, exp_rd(addrs[i], prot_on)}, {14'h0, rd});
                chk("step", addrs[i] + 22'(i[0]), mem_addr);
            end
        end
        v = 8'h80 | 8'($random(seed));
        tp_set(ERASE_OPT_ADDR);
        fr(CMD_TBL_WRITE, {8'h00, v}, 0, 0);
        chk("erase option", {14'h0, v}, {14'h0, erase_sel});
        n = busy_n;
        k = clr_n;
        fr(CMD_CORE, 16'h0000, 0, 40);
        chk("erase span", 22'(BE_CYC), 22'(busy_n - n));
        chk("protect clear", 22'h1, 22'(clr_n - k));
        core_chk(16'($random(seed)));
        v = 8'($random(seed));
        tp_set(22'h002005);
        fr(CMD_TBL_WRITE, {8'h00, v}, 0, 0);
        wbuf_rd_idx = 6'h0d;
        #1 chk("buffer", {14'h0, v}, {14'h0, wbuf_rd_data});
        tp_set(PROG_CTRL_ADDR);
        fr(CMD_TBL_WRITE, 16'h0001, 0, 0);
        chk("multi panel", 22'h1, {21'h0, multi_panel});
        tp_set(22'h002005);
        fr(CMD_START_PROG, 16'h0000, 0, 0);
        n = act_n;
        fr(CMD_CORE, 16'h0000, 40, 20);
        chk("hold span", 22'h1, {21'h0, act_n - n inside {[46:50]}});
        spvp_prog_model_inst.leave;
        chk("mode exit", 22'h0, {21'h0, io_hiz});
        end_of_test;
    end
    initial
    begin
        #400000;
        num_errors++;
        end_of_test;
    end
endmodule
